//--- design/scsc_top.sv
// System clock source control: oscillator enables, caps, clock select
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module scsc_top
   import scsc_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              srst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   output scsc_osc_ctrl_t         osc_ctrl,
   output scsc_clk_sel_t          clk_sel,
   output logic                   hang_risk
);

   ////////////////////////////////////////////////////////////////////////
   // Register state

   logic [7:0]     mode_reg;
   logic [7:0]     mode_next;
   logic [7:0]     xtal_reg;
   logic [7:0]     xtal_next;
   scsc_clk_sel_t  sel_reg;
   scsc_clk_sel_t  sel_next;
   scsc_clk_sel_t  sel_dec;
   logic           hang_reg;
   logic           hang_next;
   logic [7:0]     rdata_reg;
   logic [7:0]     rdata_next;
   logic           src_osc_on;
   logic [7:0]     status_word;

   // Decoding the next mode word lets the select change on the write edge
   scsc_mode_decode u_decode (
      .mode (mode_next),
      .sel  (sel_dec)
   );

   always_comb begin
      mode_next = mode_reg;
      xtal_next = xtal_reg;
      if (reg_wr && reg_addr == CLOCK_MODE_ADDR) begin
         mode_next = reg_wdata;
      end
      if (reg_wr && reg_addr == CRYSTAL_CONTROL_ADDR) begin
         xtal_next = reg_wdata;
      end
      sel_next = sel_dec;
      // Running from a stopped oscillator would stall the core
      case (sel_next.src)
         SRC_FAST: src_osc_on = mode_next[FAST_EN_BIT];
         SRC_SLOW: src_osc_on = mode_next[SLOW_EN_BIT];
         SRC_XTAL: src_osc_on = xtal_next[XTAL_EN_BIT];
         default:  src_osc_on = 1'b0;
      endcase
      hang_next = !src_osc_on;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mode_reg <= CLOCK_MODE_RST;
         xtal_reg <= CRYSTAL_CONTROL_RST;
         sel_reg  <= '{src: SRC_SLOW, div_log2: DIV_1};
         hang_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         xtal_reg <= xtal_next;
         sel_reg  <= sel_next;
         hang_reg <= hang_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port

   always_comb begin
      status_word = READ_IDLE;
      status_word[STAT_HANG_BIT] = hang_reg;
      status_word[STAT_SRC_HI:STAT_SRC_LO] = sel_reg.src;
      rdata_next = READ_IDLE;
      if (reg_rd) begin
         case (reg_addr)
            CLOCK_MODE_ADDR:      rdata_next = mode_reg;
            CRYSTAL_CONTROL_ADDR: rdata_next = xtal_reg;
            CLOCK_STATUS_ADDR:    rdata_next = status_word;
            default:              rdata_next = READ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata_reg <= READ_IDLE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign reg_rdata           = rdata_reg;
   assign clk_sel             = sel_reg;
   assign hang_risk           = hang_reg;
   // Whole struct from one process keeps a single driver
   always_comb begin
      osc_ctrl.crystal_en = xtal_reg[XTAL_EN_BIT];
      osc_ctrl.fast_rc_en = mode_reg[FAST_EN_BIT];
      osc_ctrl.slow_rc_en = mode_reg[SLOW_EN_BIT];
      // Cap steps only suit a 32 kHz crystal; no faster drive exists
      osc_ctrl.xin_cap    =
         scsc_cap_t'(xtal_reg[XIN_CAP_HI:XIN_CAP_LO]);
      osc_ctrl.xout_cap   =
         scsc_cap_t'(xtal_reg[XOUT_CAP_HI:XOUT_CAP_LO]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   logic wr_mode;
   logic wr_xtal;
   assign wr_mode = reg_wr && reg_addr == CLOCK_MODE_ADDR;
   assign wr_xtal = reg_wr && reg_addr == CRYSTAL_CONTROL_ADDR;

   a_crystal_enable: assert property (
      @(posedge clk_sys) disable iff (srst)
      wr_xtal |=> osc_ctrl.crystal_en == $past(reg_wdata[XTAL_EN_BIT]))
      else $error("crystal enable does not follow write");

   a_xin_cap_sel: assert property (
      @(posedge clk_sys) disable iff (srst)
      wr_xtal |=> osc_ctrl.xin_cap ==
                  $past(reg_wdata[XIN_CAP_HI:XIN_CAP_LO]))
      else $error("input cap select wrong");

   a_xout_cap_sel: assert property (
      @(posedge clk_sys) disable iff (srst)
      wr_xtal |=> osc_ctrl.xout_cap ==
                  $past(reg_wdata[XOUT_CAP_HI:XOUT_CAP_LO]))
      else $error("output cap select wrong");

   a_sel_holds: assert property (
      @(posedge clk_sys) disable iff (srst)
      !wr_mode |=> $stable(clk_sel))
      else $error("clock select moved without a mode write");

   a_sel_immediate: assert property (
      @(posedge clk_sys) disable iff (srst)
      wr_mode && reg_wdata == MODE_XTAL ##1 wr_mode &&
      reg_wdata == MODE_SLOW |=> clk_sel.src == SRC_SLOW &&
      $past(clk_sel.src) == SRC_XTAL)
      else $error("mode write not effective at once");

   a_fast_div_codes: assert property (
      @(posedge clk_sys) disable iff (srst)
      wr_mode && (reg_wdata == MODE_FAST_DIV2 ||
                  reg_wdata == MODE_FAST_DIV4) |=>
      clk_sel.src == SRC_FAST &&
      clk_sel.div_log2 == ($past(reg_wdata) == MODE_FAST_DIV2 ?
                           DIV_2 : DIV_4))
      else $error("fast RC divider code wrong");

   a_slow_xtal_codes: assert property (
      @(posedge clk_sys) disable iff (srst)
      wr_mode && (reg_wdata == MODE_SLOW || reg_wdata == MODE_XTAL) |=>
      clk_sel.src == ($past(reg_wdata) == MODE_SLOW ? SRC_SLOW : SRC_XTAL))
      else $error("slow or crystal select wrong");

   a_rc_enables: assert property (
      @(posedge clk_sys) disable iff (srst)
      wr_mode |=> osc_ctrl.fast_rc_en == $past(reg_wdata[FAST_EN_BIT]) &&
                  osc_ctrl.slow_rc_en == $past(reg_wdata[SLOW_EN_BIT]) &&
                  $stable(osc_ctrl.crystal_en))
      else $error("oscillator enables not independent");

   a_boot_rc_on: assert property (
      @(posedge clk_sys)
      srst |=> osc_ctrl.fast_rc_en && osc_ctrl.slow_rc_en &&
               !osc_ctrl.crystal_en)
      else $error("RC oscillators not on after reset");

   a_hang_flag: assert property (
      @(posedge clk_sys) disable iff (srst)
      wr_mode && !reg_wdata[FAST_EN_BIT] &&
      (reg_wdata[MODE_SRC_HI:MODE_SRC_LO] == MSRC_FAST_HI ||
       reg_wdata[MODE_SRC_HI:MODE_SRC_LO] == MSRC_FAST_LO) |=> hang_risk)
      else $error("hang hazard not flagged");

   a_hang_xtal_off: assert property (
      @(posedge clk_sys) disable iff (srst)
      wr_xtal && !reg_wdata[XTAL_EN_BIT] && clk_sel.src == SRC_XTAL |=>
      hang_risk)
      else $error("crystal stopped under running clock not flagged");

   a_xtal_readback: assert property (
      @(posedge clk_sys) disable iff (srst)
      reg_rd && reg_addr == CRYSTAL_CONTROL_ADDR |=>
      reg_rdata[XTAL_EN_BIT] == $past(osc_ctrl.crystal_en) &&
      reg_rdata[XIN_CAP_HI:XIN_CAP_LO] == $past(osc_ctrl.xin_cap) &&
      reg_rdata[XOUT_CAP_HI:XOUT_CAP_LO] == $past(osc_ctrl.xout_cap))
      else $error("crystal control reads back wrong");

   a_mode_readback: assert property (
      @(posedge clk_sys) disable iff (srst)
      reg_rd && reg_addr == CLOCK_MODE_ADDR |=>
      reg_rdata[FAST_EN_BIT] == $past(osc_ctrl.fast_rc_en) &&
      reg_rdata[SLOW_EN_BIT] == $past(osc_ctrl.slow_rc_en))
      else $error("clock mode reads back wrong");

endmodule

//--- design/scsc_pkg.sv
// Constants, types and register map of the system clock source control
package scsc_pkg;

   localparam int          ADDR_W               = 8;
   localparam int          DATA_W               = 8;

   // Register map
   localparam logic [7:0]  CLOCK_MODE_ADDR      = 8'h03;
   localparam logic [7:0]  CRYSTAL_CONTROL_ADDR = 8'h0A;
   localparam logic [7:0]  CLOCK_STATUS_ADDR    = 8'h0B;

   // Reset values: slow RC drives the clock, both RCs run, crystal off
   localparam logic [7:0]  CLOCK_MODE_RST       = 8'hF4;
   localparam logic [7:0]  CRYSTAL_CONTROL_RST  = 8'h00;
   localparam logic [7:0]  READ_IDLE            = 8'h00;

   // Crystal control fields
   localparam int          XTAL_EN_BIT          = 7;
   localparam int          XIN_CAP_HI           = 4;
   localparam int          XIN_CAP_LO           = 3;
   localparam int          XOUT_CAP_HI          = 2;
   localparam int          XOUT_CAP_LO          = 1;

   // Clock mode fields
   localparam int          MODE_SRC_HI          = 7;
   localparam int          MODE_SRC_LO          = 5;
   localparam int          FAST_EN_BIT          = 4;
   localparam int          MODE_DIV_BIT         = 3;
   localparam int          SLOW_EN_BIT          = 2;

   // Clock mode source field codes
   localparam logic [2:0]  MSRC_FAST_LO         = 3'h0;
   localparam logic [2:0]  MSRC_FAST_HI         = 3'h1;
   localparam logic [2:0]  MSRC_FAST_32         = 3'h3;
   localparam logic [2:0]  MSRC_XTAL            = 3'h5;
   localparam logic [2:0]  MSRC_SLOW            = 3'h7;

   // Divider as log2 of the ratio
   localparam logic [2:0]  DIV_1                = 3'h0;
   localparam logic [2:0]  DIV_2                = 3'h1;
   localparam logic [2:0]  DIV_4                = 3'h2;
   localparam logic [2:0]  DIV_8                = 3'h3;
   localparam logic [2:0]  DIV_16               = 3'h4;
   localparam logic [2:0]  DIV_32               = 3'h5;

   // Well-known mode words
   localparam logic [7:0]  MODE_FAST_DIV2       = 8'h34;
   localparam logic [7:0]  MODE_FAST_DIV4       = 8'h14;
   localparam logic [7:0]  MODE_SLOW            = 8'hF4;
   localparam logic [7:0]  MODE_XTAL            = 8'hB0;

   // Status fields
   localparam int          STAT_HANG_BIT        = 0;
   localparam int          STAT_SRC_LO          = 1;
   localparam int          STAT_SRC_HI          = 3;

   localparam int          CRYSTAL_KHZ          = 32;

   typedef enum logic [1:0] {
      CAP_OFF    = 2'h0,
      CAP_7PF    = 2'h1,
      CAP_9P5PF  = 2'h2,
      CAP_12P5PF = 2'h3
   } scsc_cap_t;

   typedef enum logic [2:0] {
      SRC_FAST = 3'b001,
      SRC_SLOW = 3'b010,
      SRC_XTAL = 3'b100
   } scsc_src_t;

   typedef struct packed {
      logic      crystal_en;
      logic      fast_rc_en;
      logic      slow_rc_en;
      scsc_cap_t xin_cap;
      scsc_cap_t xout_cap;
   } scsc_osc_ctrl_t;

   typedef struct packed {
      scsc_src_t  src;
      logic [2:0] div_log2;
   } scsc_clk_sel_t;

endpackage

//--- design/scsc_mode_decode.sv
// Decoder from a clock mode word to source and divider
`timescale 1ns/1ns
module scsc_mode_decode
   import scsc_pkg::*;
(
   input  wire logic [7:0]    mode,
   output scsc_clk_sel_t      sel
);

   logic [2:0] src_field;
   logic       div_bit;

   assign src_field = mode[MODE_SRC_HI:MODE_SRC_LO];
   assign div_bit   = mode[MODE_DIV_BIT];

   always_comb begin
      sel.src      = SRC_SLOW;
      sel.div_log2 = DIV_1;
      case (src_field)
         MSRC_FAST_HI: begin
            sel.src      = SRC_FAST;
            sel.div_log2 = div_bit ? DIV_8 : DIV_2;
         end
         MSRC_FAST_LO: begin
            sel.src      = SRC_FAST;
            sel.div_log2 = div_bit ? DIV_16 : DIV_4;
         end
         MSRC_FAST_32: begin
            sel.src      = SRC_FAST;
            sel.div_log2 = DIV_32;
         end
         MSRC_SLOW: begin
            sel.src      = SRC_SLOW;
         end
         MSRC_XTAL: begin
            sel.src      = SRC_XTAL;
         end
         // Unused codes fall back to the slow RC, the source selected at reset
         default: begin
            sel.src      = SRC_SLOW;
            sel.div_log2 = DIV_1;
         end
      endcase
   end

endmodule

//--- verif/scsc_tb_top.sv
// Self-checking bench for the system clock source control
`timescale 1ns/1ns
module scsc_tb_top
   import scsc_pkg::*;
;
   logic              clk_sys;
   logic              srst;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   scsc_osc_ctrl_t    osc_ctrl;
   scsc_clk_sel_t     clk_sel;
   logic              hang_risk;
   int                n_mismatch;
   int                total_checks;
   int                cycles;
   int                seed;
   logic [7:0]        mode_m;
   logic [7:0]        xtal_m;
   logic [31:0]       r;
   logic [7:0]        exp_rd;
   logic              live;
   int                modes [0:9] = '{'h34, 'h14, 'h3C, 'h1C, 'h7C,
                                      'hF4, 'h24, 'hB0, 'hE4, 'hA6};
   // Stand-in for the timer count that proves the crystal settled
   localparam int     XTAL_SETTLE = 'h2000;

   scsc_top dut (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .osc_ctrl  (osc_ctrl),
      .clk_sel   (clk_sel),
      .hang_risk (hang_risk)
   );

   ////////////////////////////////////////////////////////////////////////
   // Reference model
   function automatic logic [5:0] exp_sel(input logic [7:0] m);
      case (m[7:5])
         3'h1:    return {3'h1, m[3] ? 3'h3 : 3'h1};
         3'h0:    return {3'h1, m[3] ? 3'h4 : 3'h2};
         3'h3:    return {3'h1, 3'h5};
         3'h5:    return {3'h4, 3'h0};
         default: return {3'h2, 3'h0};
      endcase
   endfunction

   // Hang flag: the running source has its own enable cleared
   function automatic logic exp_hang();
      logic [5:0] s;
      s = exp_sel(mode_m);
      if (s[5]) return !xtal_m[7];
      if (s[3]) return !mode_m[4];
      return !mode_m[2];
   endfunction

   task automatic chk(input string what, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic outs();
      chk("clk_sel", {2'h0, clk_sel}, {2'h0, exp_sel(mode_m)});
      chk("osc_ctrl", {1'h0, osc_ctrl},
          {1'h0, xtal_m[7], mode_m[4], mode_m[2], xtal_m[4:1]});
      chk("hang_risk", {7'h0, hang_risk}, {7'h0, exp_hang()});
   endtask

   // Outputs are compared mid-cycle, where they have settled
   always @(negedge clk_sys) begin
      if (live) begin
         chk("reg_rdata", reg_rdata, exp_rd);
         outs();
      end
   end

   // One bus cycle; back to back calls leave no idle gap
   task automatic op(input logic w, input logic [7:0] a, d);
      logic [5:0] s;
      logic [7:0] e;
      s = exp_sel(mode_m);
      e = READ_IDLE;
      if (a == CLOCK_MODE_ADDR) e = mode_m;
      if (a == CRYSTAL_CONTROL_ADDR) e = xtal_m;
      if (a == CLOCK_STATUS_ADDR) e = {4'h0, s[5:3], exp_hang()};
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      if (w && a == CLOCK_MODE_ADDR) mode_m = d;
      if (w && a == CRYSTAL_CONTROL_ADDR) xtal_m = d;
      exp_rd = w ? READ_IDLE : e;
   endtask

   task automatic idle();
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      @(posedge clk_sys);
      exp_rd = READ_IDLE;
      @(negedge clk_sys);
      chk("rdata idle", reg_rdata, READ_IDLE);
   endtask

   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Hang guard; the run needs about 8400 cycles, mostly the settle wait
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 12000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial begin
      seed = 61;
      live = 1'h0;
      exp_rd = READ_IDLE;
      srst = 1'h1;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      mode_m = 8'hF4;
      xtal_m = 8'h00;
      repeat (20) @(posedge clk_sys);
      srst <= 1'h0;
      live = 1'h1;
      @(negedge clk_sys);
      outs();
      @(posedge clk_sys);
      op(1'h0, CLOCK_MODE_ADDR, 8'h00);
      op(1'h0, CRYSTAL_CONTROL_ADDR, 8'h00);
      // Every cap code on both sides, enable off for the first four, on for the last four
      for (int i = 0; i < 8; i++) begin
         op(1'h1, CRYSTAL_CONTROL_ADDR,
            {i[2], 2'h0, i[1:0], ~i[1:0], i[0]});
         op(1'h0, CRYSTAL_CONTROL_ADDR, 8'h00);
      end
      idle();
      repeat (XTAL_SETTLE) @(posedge clk_sys);
      // Mode words back to back with status reads
      foreach (modes[k]) begin
         op(1'h1, CLOCK_MODE_ADDR, modes[k][7:0]);
         op(1'h0, CLOCK_STATUS_ADDR, 8'h00);
      end
      op(1'h1, CLOCK_MODE_ADDR, MODE_XTAL);
      op(1'h1, CLOCK_MODE_ADDR, MODE_SLOW);
      op(1'h1, CLOCK_MODE_ADDR, MODE_XTAL);
      op(1'h1, CRYSTAL_CONTROL_ADDR, 8'h00);
      op(1'h1, CLOCK_STATUS_ADDR, 8'hFF);
      // Random traffic, read-only and unmapped places included
      for (int i = 0; i < 80; i++) begin
         r = $random(seed);
         case (r[9:8])
            2'h0:    op(r[12], CLOCK_MODE_ADDR, r[7:0]);
            2'h1:    op(r[12], CRYSTAL_CONTROL_ADDR, r[7:0]);
            2'h2:    op(r[12], CLOCK_STATUS_ADDR, r[7:0]);
            default: op(r[12], {1'h1, r[22:16]}, r[7:0]);
         endcase
      end
      // Move off the crystal before stopping it, then reset mid-run
      op(1'h1, CLOCK_MODE_ADDR, MODE_SLOW);
      op(1'h1, CRYSTAL_CONTROL_ADDR, 8'h00);
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      srst <= 1'h1;
      @(posedge clk_sys);
      srst <= 1'h0;
      mode_m = 8'hF4;
      xtal_m = 8'h00;
      exp_rd = READ_IDLE;
      @(negedge clk_sys);
      outs();
      @(posedge clk_sys);
      op(1'h0, CLOCK_MODE_ADDR, 8'h00);
      op(1'h0, CRYSTAL_CONTROL_ADDR, 8'h00);
      idle();
      give_verdict();
   end
endmodule
